// >>> mdfsb_pkg.sv
package mdfsb_pkg;

    // register port geometry
    localparam int unsigned MDFSB_ADDR_W = 8;
    localparam int unsigned MDFSB_DATA_W = 32;

    // register offsets
    localparam logic [7:0] MDFSB_GATE_WORD_OFFSET = 8'he0;
    localparam logic [7:0] MDFSB_CTRL_WORD_OFFSET = 8'he2;

    // reset values
    localparam logic [31:0] MDFSB_WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] MDFSB_READ_UNMAPPED = 32'h0000_0000;

    // gate-driver fault word fields
    localparam int unsigned MDFSB_GD_SUMMARY = 31;
    localparam int unsigned MDFSB_GD_P2_HS_OC = 19;
    localparam int unsigned MDFSB_GD_P2_LS_OC = 18;
    localparam int unsigned MDFSB_GD_P1_HS_OC = 17;
    localparam int unsigned MDFSB_GD_P1_LS_OC = 16;
    localparam int unsigned MDFSB_GD_OTP_ERR = 14;
    localparam int unsigned MDFSB_GD_BUCK_OC = 13;
    localparam int unsigned MDFSB_GD_BUCK_LV = 12;
    localparam int unsigned MDFSB_GD_CP_LV = 11;

    // controller fault word fields
    localparam int unsigned MDFSB_CT_SUMMARY = 31;
    localparam int unsigned MDFSB_CT_OVERTEMP_WARN = 30;
    localparam int unsigned MDFSB_CT_PD_FREQ = 29;
    localparam int unsigned MDFSB_CT_PD_T1 = 28;
    localparam int unsigned MDFSB_CT_PD_T2 = 27;
    localparam int unsigned MDFSB_CT_BUS_ILIM = 26;
    localparam int unsigned MDFSB_CT_RL_MEAS = 25;
    localparam int unsigned MDFSB_CT_BEMF_MEAS = 24;
    localparam int unsigned MDFSB_CT_ABNORMAL_SPEED_LOCK = 23;
    localparam int unsigned MDFSB_CT_ABNORMAL_BACK_EMF_LOCK = 22;
    localparam int unsigned MDFSB_CT_NO_MOTOR = 21;
    localparam int unsigned MDFSB_CT_ANY_LOCK = 20;
    localparam int unsigned MDFSB_CT_ILIM_LOCK = 19;
    localparam int unsigned MDFSB_CT_HW_ILIM_LOCK = 18;
    localparam int unsigned MDFSB_CT_SUPPLY_LOW = 17;
    localparam int unsigned MDFSB_CT_SUPPLY_HIGH = 16;
    localparam int unsigned MDFSB_CT_SPEED_SAT = 15;
    localparam int unsigned MDFSB_CT_CURR_SAT = 14;
    localparam int unsigned MDFSB_CT_WATCHDOG = 3;
    localparam int unsigned MDFSB_CT_SELFTEST_EN = 2;
    localparam int unsigned MDFSB_CT_SELFTEST = 1;
    localparam int unsigned MDFSB_CT_APP_RESET = 0;

    // field masks: live bits, bits feeding the summaries, lock sources
    localparam logic [31:0] MDFSB_GD_LIVE_MASK = 32'h000f_7800;
    localparam logic [31:0] MDFSB_CT_LIVE_MASK = 32'h7fef_c00f;
    localparam logic [31:0] MDFSB_CT_FAULT_MASK = 32'h7fff_c008;
    localparam logic [31:0] MDFSB_CT_LOCK_MASK = 32'h00ec_0000;

endpackage : mdfsb_pkg

// >>> mdfsb_capture.sv
`timescale 1ns/10ps

// registers a word of live fault levels; bits outside the mask never leave zero
module mdfsb_capture #(
    parameter int unsigned WIDTH = 32,
    parameter logic [31:0] LIVE_MASK = 32'h0000_0000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // raw levels and registered word
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] word_r
);
    import mdfsb_pkg::*;

    logic [WIDTH-1:0] word_nxt;

    always_comb begin
        word_nxt = raw & LIVE_MASK[WIDTH-1:0];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            word_r <= '0;
        end else begin
            word_r <= word_nxt;
        end
    end

endmodule : mdfsb_capture

// >>> mdfsb_fault_bank.sv
`timescale 1ns/10ps

import mdfsb_pkg::*;

// Summary of operation
// - gate word bits 19 and 18 show phase-two high and low side overcurrent
// - gate word bits 17 and 16 show phase-one high and low side overcurrent
// - gate word bit 14 shows a programmable memory error
// - gate word bit 13 shows step-down regulator overcurrent
// - gate word bit 12 shows step-down regulator undervoltage
// - gate word bit 11 shows charge pump undervoltage
// - controller word bit 31 is the OR of all controller faults
// - controller bits 29, 28, 27 show position detect frequency and timing faults
// - controller bit 26 shows supply bus current limit active
// - controller bit 25 shows resistance and inductance measure error
// - controller bit 24 shows back-emf constant measure error
// - controller bit 23 shows abnormal speed motor lock
// - controller bit 22 shows abnormal back-emf motor lock
// - controller bit 21 shows no motor connected
// - controller bit 20 is set whenever any motor lock detection fired
// - controller bits 19 and 18 show current-limit and hardware current-limit locks
// - controller bits 17 and 16 show motor supply low and high faults
// - controller bits 15 and 14 show speed and current loop saturation
// - gate word bit 31 is the OR of its fault bits and drives the active-low fault pin inverted
module mdfsb_fault_bank (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // host register port
    input wire logic [mdfsb_pkg::MDFSB_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [mdfsb_pkg::MDFSB_DATA_W-1:0] reg_wdata,
    output logic [mdfsb_pkg::MDFSB_DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_wack,
    // gate-driver fault levels
    input wire logic phase_two_high_side_overcurrent,
    input wire logic phase_two_low_side_overcurrent,
    input wire logic phase_one_high_side_overcurrent,
    input wire logic phase_one_low_side_overcurrent,
    input wire logic otp_error,
    input wire logic step_down_regulator_overcurrent,
    input wire logic step_down_regulator_undervoltage,
    input wire logic charge_pump_low_voltage,
    // controller fault levels
    input wire logic overtemp_warning,
    input wire logic position_detect_frequency_fault,
    input wire logic position_detect_first_timing_fault,
    input wire logic position_detect_second_timing_fault,
    input wire logic bus_current_limit_active,
    input wire logic resistance_inductance_measure_error,
    input wire logic back_emf_measure_error,
    input wire logic abnormal_speed_lock,
    input wire logic abnormal_back_emf_lock,
    input wire logic motor_absent_fault,
    input wire logic current_limit_lock_fault,
    input wire logic hardware_current_limit_lock_fault,
    input wire logic motor_supply_low_fault,
    input wire logic motor_supply_high_fault,
    input wire logic speed_loop_saturation,
    input wire logic current_loop_saturation,
    input wire logic watchdog_fault,
    input wire logic selftest_enable_status,
    input wire logic selftest_status,
    input wire logic app_reset_flag,
    // fault pin, active low
    output logic fault_output_pin_n
);
    import mdfsb_pkg::*;

    logic [31:0] gate_raw;
    logic [31:0] ctrl_raw;
    logic [31:0] gate_live_r;
    logic [31:0] ctrl_live_r;
    logic [31:0] gate_word;
    logic [31:0] ctrl_word;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic wack_r;
    logic any_lock;

    // pack the live levels at their field positions
    always_comb begin
        gate_raw = '0;
        gate_raw[MDFSB_GD_P2_HS_OC] = phase_two_high_side_overcurrent;
        gate_raw[MDFSB_GD_P2_LS_OC] = phase_two_low_side_overcurrent;
        gate_raw[MDFSB_GD_P1_HS_OC] = phase_one_high_side_overcurrent;
        gate_raw[MDFSB_GD_P1_LS_OC] = phase_one_low_side_overcurrent;
        gate_raw[MDFSB_GD_OTP_ERR] = otp_error;
        gate_raw[MDFSB_GD_BUCK_OC] = step_down_regulator_overcurrent;
        gate_raw[MDFSB_GD_BUCK_LV] = step_down_regulator_undervoltage;
        gate_raw[MDFSB_GD_CP_LV] = charge_pump_low_voltage;
    end

    always_comb begin
        ctrl_raw = '0;
        ctrl_raw[MDFSB_CT_OVERTEMP_WARN] = overtemp_warning;
        ctrl_raw[MDFSB_CT_PD_FREQ] = position_detect_frequency_fault;
        ctrl_raw[MDFSB_CT_PD_T1] = position_detect_first_timing_fault;
        ctrl_raw[MDFSB_CT_PD_T2] = position_detect_second_timing_fault;
        ctrl_raw[MDFSB_CT_BUS_ILIM] = bus_current_limit_active;
        ctrl_raw[MDFSB_CT_RL_MEAS] = resistance_inductance_measure_error;
        ctrl_raw[MDFSB_CT_BEMF_MEAS] = back_emf_measure_error;
        ctrl_raw[MDFSB_CT_ABNORMAL_SPEED_LOCK] = abnormal_speed_lock;
        ctrl_raw[MDFSB_CT_ABNORMAL_BACK_EMF_LOCK] = abnormal_back_emf_lock;
        ctrl_raw[MDFSB_CT_NO_MOTOR] = motor_absent_fault;
        ctrl_raw[MDFSB_CT_ILIM_LOCK] = current_limit_lock_fault;
        ctrl_raw[MDFSB_CT_HW_ILIM_LOCK] = hardware_current_limit_lock_fault;
        ctrl_raw[MDFSB_CT_SUPPLY_LOW] = motor_supply_low_fault;
        ctrl_raw[MDFSB_CT_SUPPLY_HIGH] = motor_supply_high_fault;
        ctrl_raw[MDFSB_CT_SPEED_SAT] = speed_loop_saturation;
        ctrl_raw[MDFSB_CT_CURR_SAT] = current_loop_saturation;
        ctrl_raw[MDFSB_CT_WATCHDOG] = watchdog_fault;
        ctrl_raw[MDFSB_CT_SELFTEST_EN] = selftest_enable_status;
        ctrl_raw[MDFSB_CT_SELFTEST] = selftest_status;
        ctrl_raw[MDFSB_CT_APP_RESET] = app_reset_flag;
    end

    // the masks keep reserved and summary positions at zero in the flops
    mdfsb_capture #(
        .WIDTH(32),
        .LIVE_MASK(MDFSB_GD_LIVE_MASK)
    ) u_gate_capture (
        .mclk(mclk),
        .rst(rst),
        .raw(gate_raw),
        .word_r(gate_live_r)
    );

    mdfsb_capture #(
        .WIDTH(32),
        .LIVE_MASK(MDFSB_CT_LIVE_MASK)
    ) u_ctrl_capture (
        .mclk(mclk),
        .rst(rst),
        .raw(ctrl_raw),
        .word_r(ctrl_live_r)
    );

    // summaries are formed from the registered bits so word and pin never disagree
    always_comb begin
        any_lock = |(ctrl_live_r & MDFSB_CT_LOCK_MASK);
        gate_word = gate_live_r;
        gate_word[MDFSB_GD_SUMMARY] = |(gate_live_r & MDFSB_GD_LIVE_MASK);
        ctrl_word = ctrl_live_r;
        ctrl_word[MDFSB_CT_ANY_LOCK] = any_lock;
        ctrl_word[MDFSB_CT_SUMMARY] = any_lock | (|(ctrl_live_r & MDFSB_CT_FAULT_MASK));
    end

    assign fault_output_pin_n = ~gate_word[MDFSB_GD_SUMMARY];

    // read mux; unmapped offsets return zero
    always_comb begin
        case (reg_addr)
            MDFSB_GATE_WORD_OFFSET: rdata_nxt = gate_word;
            MDFSB_CTRL_WORD_OFFSET: rdata_nxt = ctrl_word;
            default: rdata_nxt = MDFSB_READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= MDFSB_WORD_RESET;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd;
        end
    end

    // writes are acknowledged unless a read comes in the same cycle, and always dropped: there is no storage for reg_wdata to reach
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wack_r <= 1'b0;
        end else begin
            wack_r <= reg_wr & ~reg_rd;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign reg_wack = wack_r;

    // checks
    // the words still show reset zeros up to the first edge after release, so checks wait two edges until the capture refills
    logic [1:0] settle_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            settle_r <= 2'h0;
        end else begin
            settle_r <= {settle_r[0], 1'h1};
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst || !settle_r[1]);

    sequence rd_gate;
        reg_rd && reg_addr == MDFSB_GATE_WORD_OFFSET;
    endsequence

    sequence rd_ctrl;
        reg_rd && reg_addr == MDFSB_CTRL_WORD_OFFSET;
    endsequence

    chk_p2_oc_bits: assert property (
        rd_gate |=> reg_rvalid && reg_rdata[19] == $past(phase_two_high_side_overcurrent, 2)
            && reg_rdata[18] == $past(phase_two_low_side_overcurrent, 2))
        else $error("phase two overcurrent bits wrong");

    chk_p1_oc_bits: assert property (
        rd_gate |=> reg_rvalid && reg_rdata[17] == $past(phase_one_high_side_overcurrent, 2)
            && reg_rdata[16] == $past(phase_one_low_side_overcurrent, 2))
        else $error("phase one overcurrent bits wrong");

    chk_otp_err_bit: assert property (
        rd_gate |=> reg_rdata[14] == $past(otp_error, 2))
        else $error("memory error bit wrong");

    chk_buck_oc_bit: assert property (
        rd_gate |=> reg_rdata[13] == $past(step_down_regulator_overcurrent, 2))
        else $error("regulator overcurrent bit wrong");

    chk_buck_lv_bit: assert property (
        rd_gate |=> reg_rdata[12] == $past(step_down_regulator_undervoltage, 2))
        else $error("regulator undervoltage bit wrong");

    chk_cp_lv_bit: assert property (
        rd_gate |=> reg_rdata[11] == $past(charge_pump_low_voltage, 2))
        else $error("charge pump bit wrong");

    chk_ctrl_summary: assert property (
        rd_ctrl |=> reg_rdata[31] == (|(reg_rdata & MDFSB_CT_FAULT_MASK)))
        else $error("controller summary is not the OR of its faults");

    chk_ctrl_summary_live: assert property (
        watchdog_fault ##1 watchdog_fault |-> ctrl_word[31])
        else $error("controller summary missed a held fault");

    chk_pos_detect_bits: assert property (
        rd_ctrl |=> reg_rdata[29:27] == {$past(position_detect_frequency_fault, 2),
            $past(position_detect_first_timing_fault, 2), $past(position_detect_second_timing_fault, 2)})
        else $error("position detect bits wrong");

    chk_bus_ilim_bit: assert property (
        $rose(bus_current_limit_active) |=> ctrl_word[26])
        else $error("bus current limit bit late");

    chk_rl_meas_bit: assert property (
        rd_ctrl |=> reg_rdata[25] == $past(resistance_inductance_measure_error, 2))
        else $error("resistance measure bit wrong");

    chk_bemf_meas_bit: assert property (
        rd_ctrl |=> reg_rdata[24] == $past(back_emf_measure_error, 2))
        else $error("back-emf measure bit wrong");

    chk_abnormal_speed_lock_bit: assert property (
        abnormal_speed_lock |=> ctrl_word[23] && ctrl_word[20] && ctrl_word[31])
        else $error("abnormal speed lock not shown");

    chk_abnormal_back_emf_lock_bit: assert property (
        abnormal_back_emf_lock |=> ctrl_word[22] && ctrl_word[20])
        else $error("abnormal back-emf lock not shown");

    chk_no_motor_bit: assert property (
        $fell(motor_absent_fault) |=> !ctrl_word[21])
        else $error("motor absent bit did not clear");

    chk_any_lock_bit: assert property (
        ctrl_word[20] == (ctrl_word[23] | ctrl_word[22] | ctrl_word[21] | ctrl_word[19] | ctrl_word[18]))
        else $error("any lock bit disagrees with lock sources");

    chk_ilim_lock_bits: assert property (
        rd_ctrl |=> reg_rdata[19:18] == {$past(current_limit_lock_fault, 2),
            $past(hardware_current_limit_lock_fault, 2)})
        else $error("current limit lock bits wrong");

    chk_supply_bits: assert property (
        rd_ctrl |=> reg_rdata[17:16] == {$past(motor_supply_low_fault, 2), $past(motor_supply_high_fault, 2)})
        else $error("motor supply bits wrong");

    chk_loop_sat_bits: assert property (
        rd_ctrl |=> reg_rdata[15:14] == {$past(speed_loop_saturation, 2), $past(current_loop_saturation, 2)})
        else $error("loop saturation bits wrong");

    chk_fault_pin: assert property (
        fault_output_pin_n == !(|(gate_word & MDFSB_GD_LIVE_MASK)))
        else $error("fault pin disagrees with gate word");

    chk_gate_summary: assert property (
        rd_gate |=> reg_rdata[31] == (|(reg_rdata & MDFSB_GD_LIVE_MASK)))
        else $error("gate summary is not the OR of its faults");

    chk_write_ignored: assert property (
        reg_wr && !reg_rd && $stable(gate_raw) && $stable(ctrl_raw) |=> reg_wack ##0 gate_word == $past(gate_word)
            || $past(gate_raw) != $past(gate_raw, 2))
        else $error("write disturbed a fault word");

    chk_reserved_zero: assert property (
        (gate_word & ~(MDFSB_GD_LIVE_MASK | 32'h8000_0000)) == '0
            && (ctrl_word & ~(MDFSB_CT_LIVE_MASK | 32'h8010_0000)) == '0)
        else $error("reserved bit is set");

    chk_read_timing: assert property (
        reg_rd |=> reg_rvalid ##1 (!reg_rvalid || $past(reg_rd)))
        else $error("read answer timing wrong");

    chk_read_wins: assert property (
        reg_wr && reg_rd |=> reg_rvalid && !reg_wack)
        else $error("write acknowledged during a read");

    chk_unmapped_zero: assert property (
        reg_rd && reg_addr != MDFSB_GATE_WORD_OFFSET && reg_addr != MDFSB_CTRL_WORD_OFFSET
            |=> reg_rdata == MDFSB_READ_UNMAPPED)
        else $error("unmapped read returned data");

    cov_gate_fault: cover property (rd_gate ##1 reg_rdata[31]);
    cov_ctrl_lock: cover property (rd_ctrl ##1 reg_rdata[20]);
    cov_write_drop: cover property (reg_wr ##1 reg_wack);
    cov_pin_fall: cover property ($fell(fault_output_pin_n));
    cov_read_with_write: cover property (reg_wr && reg_rd ##1 reg_rvalid);

endmodule : mdfsb_fault_bank

// >>> tb_mdfsb.sv
`timescale 1ns/10ps

`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp); \
        end \
    end

module tb;
    import mdfsb_pkg::*;

    // clock, reset and register port
    logic mclk;
    logic rst;
    logic [7:0] reg_addr;
    logic reg_rd;
    logic reg_wr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic reg_wack;
    logic fault_output_pin_n;
    // [27:20] gate inputs, [19:0] controller inputs, in port order
    logic [27:0] flt;
    logic [31:0] exp_q[$];
    logic [31:0] exp_w;
    logic [31:0] seed;
    int n_mismatch;
    int comparisons;
    int cycles;

    mdfsb_fault_bank i_dut (
        .mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wack(reg_wack),
        .phase_two_high_side_overcurrent(flt[27]), .phase_two_low_side_overcurrent(flt[26]),
        .phase_one_high_side_overcurrent(flt[25]), .phase_one_low_side_overcurrent(flt[24]),
        .otp_error(flt[23]), .step_down_regulator_overcurrent(flt[22]),
        .step_down_regulator_undervoltage(flt[21]), .charge_pump_low_voltage(flt[20]),
        .overtemp_warning(flt[19]), .position_detect_frequency_fault(flt[18]),
        .position_detect_first_timing_fault(flt[17]), .position_detect_second_timing_fault(flt[16]),
        .bus_current_limit_active(flt[15]), .resistance_inductance_measure_error(flt[14]),
        .back_emf_measure_error(flt[13]), .abnormal_speed_lock(flt[12]),
        .abnormal_back_emf_lock(flt[11]), .motor_absent_fault(flt[10]),
        .current_limit_lock_fault(flt[9]), .hardware_current_limit_lock_fault(flt[8]),
        .motor_supply_low_fault(flt[7]), .motor_supply_high_fault(flt[6]),
        .speed_loop_saturation(flt[5]), .current_loop_saturation(flt[4]),
        .watchdog_fault(flt[3]), .selftest_enable_status(flt[2]),
        .selftest_status(flt[1]), .app_reset_flag(flt[0]),
        .fault_output_pin_n(fault_output_pin_n)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] gate_of(input logic [27:0] f);
        logic [31:0] g;
        g = 32'h0000_0000;
        g[19:16] = f[27:24];
        g[14:11] = f[23:20];
        g[31] = |g;
        return g;
    endfunction : gate_of

    function automatic logic [31:0] ctrl_of(input logic [27:0] f);
        logic [31:0] c;
        c = 32'h0000_0000;
        c[30:21] = f[19:10];
        c[19:14] = f[9:4];
        c[3:0] = f[3:0];
        c[20] = c[23] | c[22] | c[21] | c[19] | c[18];
        c[31] = (|c[30:14]) | c[3];
        return c;
    endfunction : ctrl_of

    // the read stays high, so consecutive calls give back-to-back reads
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
    endtask : rd

    task automatic idle();
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic rd_too);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_rd <= rd_too;
        reg_addr <= a;
        reg_wdata <= d;
        if (rd_too) exp_q.push_back(gate_of(flt));
        idle();
        // the acknowledge launched at this edge is settled by the next one
        @(posedge mclk);
        `CHK(reg_wack, ~rd_too)
    endtask : wr

    // inputs held three cycles so both words and the pin have settled
    task automatic setf(input logic [27:0] v);
        @(posedge mclk);
        flt <= v;
        repeat (3) @(posedge mclk);
    endtask : setf

    task automatic check_words();
        logic [31:0] g;
        g = gate_of(flt);
        `CHK(fault_output_pin_n, ~g[31])
        rd(MDFSB_GATE_WORD_OFFSET, gate_of(flt));
        rd(MDFSB_CTRL_WORD_OFFSET, ctrl_of(flt));
        idle();
        repeat (2) @(posedge mclk);
    endtask : check_words

    task automatic test_done();
        `CHK(exp_q.size(), 0)
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // read answers are matched against the oldest note
    always @(posedge mclk) begin
        if (rst === 1'b0 && reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("CHECK FAILED at %0t ns: read answer with nothing pending", $time);
            end else begin
                exp_w = exp_q.pop_front();
                `CHK(reg_rdata, exp_w)
            end
        end
    end

    // whole run is well under two thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t ns: run took too long", $time);
            test_done();
        end
    end

    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 32'h0000_0000;
        flt = 28'h000_0000;
        seed = 32'd31767;
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        repeat (5) @(posedge mclk);
        `CHK(reg_rdata, MDFSB_WORD_RESET)
        `CHK(fault_output_pin_n, 1'b1)
        rst <= 1'b0;
        check_words();
        $display("test reset values done");
        for (int i = 0; i < 28; i++) begin
            setf(28'h000_0001 << i);
            check_words();
        end
        $display("test single fault walk done");
        for (int i = 0; i < 40; i++) begin
            setf(28'(rnd()));
            check_words();
        end
        $display("test random faults done");
        setf(28'(rnd()));
        wr(MDFSB_GATE_WORD_OFFSET, 32'hffff_ffff, 1'b0);
        wr(MDFSB_CTRL_WORD_OFFSET, 32'hffff_ffff, 1'b0);
        wr(MDFSB_GATE_WORD_OFFSET, 32'h0000_0000, 1'b1);
        repeat (2) @(posedge mclk);
        check_words();
        foreach (flt[i]) begin
            if (i < 4) rd(8'he1 + 8'(i * 2), MDFSB_READ_UNMAPPED);
        end
        rd(8'h00, MDFSB_READ_UNMAPPED);
        idle();
        repeat (2) @(posedge mclk);
        $display("test writes and unmapped reads done");
        setf(28'hfff_ffff);
        check_words();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        `CHK(reg_rdata, MDFSB_WORD_RESET)
        `CHK(fault_output_pin_n, 1'b1)
        `CHK(reg_rvalid, 1'b0)
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        check_words();
        $display("test reset in mid-run done");
        test_done();
    end

endmodule : tb
